/* fle_pkg.sv */
package fle_pkg;
    localparam int LIST_N = 512;
    localparam int ADDR_W = 9;
    localparam int STK_N = 32;
    localparam int DEP_W = 6;
    localparam int VO_N = 96;
    localparam int TMR_N = 32;
    localparam int OS_N = 64;
    localparam int LAT_N = 64;
    localparam int OPND_N = 64;
    localparam int GATE_MAX = 16;
    localparam int DLY_W = 8;
    localparam int ARG_W = 7;
    localparam int CLK_MHZ = 250;
    localparam int PASS_US = 1000;
    localparam int PASS_CYC = PASS_US * CLK_MHZ;
    localparam int DIV_W = 18;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 9'h1FF;
    localparam logic [DEP_W-1:0] DEP_MAX = 6'h20;
    localparam logic [ARG_W-1:0] VO_LIM = 7'h60;
    localparam logic [4:0] GATE_LO = 5'h02;
    localparam logic [4:0] GATE_HI = 5'h10;

    typedef enum logic [4:0] {
        OP_END = 5'h00,
        OP_IN = 5'h01,
        OP_VO = 5'h02,
        OP_ON = 5'h04,
        OP_OFF = 5'h05,
        OP_NOT = 5'h06,
        OP_OR = 5'h07,
        OP_AND = 5'h08,
        OP_NOR = 5'h09,
        OP_NAND = 5'h0A,
        OP_XOR = 5'h0B,
        OP_LATCH = 5'h0C,
        OP_TIMER = 5'h0D,
        OP_ASSIGN = 5'h0E,
        OP_POS = 5'h0F,
        OP_NEG = 5'h10,
        OP_DUAL = 5'h11
    } fle_op_t;

    typedef struct packed {
        fle_op_t op;
        logic [ARG_W-1:0] arg;
    } fle_entry_t;

    typedef enum logic [2:0] {
        ST_CLEAR = 3'h1,
        ST_IDLE = 3'h2,
        ST_RUN = 3'h4
    } fle_phase_t;
endpackage

/* fle_timer_bank.sv */
`timescale 1ns/1ps
module fle_timer_bank
    import fle_pkg::*;
(
    input wire logic clk_i, // Core clock.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic tick_i, // One pulse at the end of each pass.
    input wire logic clr_i, // Recompile pulse.
    input wire logic [TMR_N-1:0] start_i, // Start level per timer.
    input wire logic [TMR_N-1:0][DLY_W-1:0] dly_i, // Pickup delay in passes.
    output logic [TMR_N-1:0] done_o // Timer outputs.
);
    typedef struct packed {
        logic [TMR_N-1:0][DLY_W-1:0] cnt;
        logic [TMR_N-1:0] done;
    } fle_tmr_st_t;

    fle_tmr_st_t st_r;
    fle_tmr_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clr_i) begin
            st_nxt = '0;
        end else if (tick_i) begin
            for (int i = 0; i < TMR_N; i++) begin
                if (!start_i[i]) begin
                    st_nxt.cnt[i] = '0;
                    st_nxt.done[i] = 1'b0;
                end else if (st_r.cnt[i] >= dly_i[i]) begin
                    st_nxt.done[i] = 1'b1;
                end else begin
                    st_nxt.cnt[i] = DLY_W'(st_r.cnt[i] + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done_o = st_r.done;

    property p_tmr_drop;
        @(posedge clk_i) disable iff (rst_i)
        tick_i && !clr_i && !start_i[0] |=> !done_o[0] ##1 !done_o[0] || tick_i;
    endproperty
    a_tmr_drop: assert property (p_tmr_drop) else $error("timer output stayed after start fell");

    property p_tmr_zero;
        @(posedge clk_i) disable iff (rst_i)
        tick_i && !clr_i && start_i[1] && dly_i[1] == '0 |=> done_o[1];
    endproperty
    a_tmr_zero: assert property (p_tmr_zero) else $error("zero delay timer did not pick up");
endmodule

/* fle_evaluator.sv */
`timescale 1ns/1ps
module fle_evaluator
    import fle_pkg::*;
#(
    parameter int PASS_CYCLES = PASS_CYC
) (
    input wire logic CORE_CLK_I, // Core clock, 250 MHz.
    input wire logic RESET_I, // Asynchronous reset, active high.
    input wire logic [OPND_N-1:0] OPND_I, // Asynchronous operand levels.
    input wire logic LIST_WE_I, // List entry write strobe.
    input wire logic [ADDR_W-1:0] LIST_ADDR_I, // List entry address.
    input wire fle_entry_t LIST_DATA_I, // List entry data.
    input wire logic LIST_CLR_I, // Clear whole list to end markers.
    input wire logic [TMR_N-1:0][DLY_W-1:0] TMR_DLY_I, // Timer pickup delays.
    output logic [VO_N-1:0] VOUT_O, // Virtual outputs.
    output logic SYNTAX_ERR_O, // List syntax error.
    output logic BUSY_O, // Clearing or evaluating.
    output logic PASS_DONE_O // One pulse per finished pass.
);
    typedef struct packed {
        fle_phase_t ph;
        logic [ADDR_W-1:0] addr;
        logic [STK_N-1:0] stk;
        logic [DEP_W-1:0] dep;
        logic [VO_N-1:0] vo;
        logic [LAT_N-1:0] lat;
        logic [OS_N-1:0] osp;
        logic [TMR_N-1:0] seen_t;
        logic [VO_N-1:0] seen_v;
        logic [TMR_N-1:0] tstart;
        logic err;
        logic busy;
        logic done;
        logic tick_t;
        logic recomp;
        logic [DIV_W-1:0] div;
        logic [OPND_N-1:0] in_m;
        logic [OPND_N-1:0] in_s;
    } fle_eval_st_t;

    localparam fle_eval_st_t ST_RST = '{ph: ST_CLEAR, busy: 1'b1, default: '0};

    fle_eval_st_t st_r;
    fle_eval_st_t st_nxt;
    fle_entry_t list_mem [LIST_N];
    fle_entry_t ent;
    logic [ARG_W-1:0] arg;
    logic [5:0] idx;
    logic [4:0] n5;
    logic [TMR_N-1:0] tmr_done;
    logic [DEP_W-1:0] pop_n;
    logic [DEP_W-1:0] dep_n;
    logic [STK_N-1:0] popped;
    logic push;
    logic bit_v;
    logic bad;
    logic fin;
    logic eq_end;
    logic tick;
    logic run;
    logic wr;

    function automatic logic gate_eval(input fle_op_t op, input logic [GATE_MAX-1:0] v,
                                       input logic [4:0] n);
        logic [GATE_MAX-1:0] m;
        logic any1;
        logic all1;
        m = ~(16'hFFFF << n);
        any1 = |(v & m);
        all1 = ((v & m) == m);
        case (op)
            OP_OR: return any1;
            OP_AND: return all1;
            OP_NOR: return ~any1;
            default: return ~all1;
        endcase
    endfunction

    assign ent = list_mem[st_r.addr];
    assign arg = ent.arg;
    assign idx = ent.arg[5:0];
    assign n5 = ent.arg[4:0];
    assign run = (st_r.ph == ST_RUN);
    assign wr = LIST_WE_I || LIST_CLR_I;

    always_comb begin
        st_nxt = st_r;
        pop_n = '0;
        push = 1'b0;
        bit_v = 1'b0;
        bad = 1'b0;
        fin = 1'b0;
        eq_end = 1'b0;
        st_nxt.in_m = OPND_I;
        st_nxt.in_s = st_r.in_m;
        st_nxt.done = 1'b0;
        st_nxt.tick_t = 1'b0;
        st_nxt.recomp = 1'b0;
        tick = (st_r.div == DIV_W'(PASS_CYCLES - 1));
        st_nxt.div = tick ? '0 : DIV_W'(st_r.div + 1'b1);
        if (run) begin
            case (ent.op)
                OP_END: fin = 1'b1;
                OP_IN: begin
                    push = 1'b1;
                    bit_v = st_r.in_s[idx];
                    bad = ent.arg[6];
                end
                OP_VO: begin
                    push = 1'b1;
                    bit_v = (arg < VO_LIM) ? st_r.vo[arg] : 1'b0;
                    bad = (arg >= VO_LIM);
                end
                OP_ON, OP_OFF: begin
                    push = 1'b1;
                    bit_v = (ent.op == OP_ON);
                end
                OP_NOT: begin
                    pop_n = 6'h01;
                    push = 1'b1;
                    bit_v = ~st_r.stk[0];
                end
                OP_OR, OP_AND, OP_NOR, OP_NAND: begin
                    pop_n = {1'b0, n5};
                    push = 1'b1;
                    bit_v = gate_eval(ent.op, st_r.stk[GATE_MAX-1:0], n5);
                    bad = (n5 < GATE_LO) || (n5 > GATE_HI) || (arg[6:5] != 2'h0);
                end
                OP_XOR: begin
                    pop_n = 6'h02;
                    push = 1'b1;
                    bit_v = st_r.stk[0] ^ st_r.stk[1];
                end
                OP_LATCH: begin
                    pop_n = 6'h02;
                    push = 1'b1;
                    // Reset is the top result, set the one beneath it.
                    bit_v = st_r.stk[0] ? 1'b0 : (st_r.stk[1] | st_r.lat[idx]);
                    st_nxt.lat[idx] = bit_v;
                    bad = ent.arg[6];
                end
                OP_TIMER: begin
                    pop_n = 6'h01;
                    push = 1'b1;
                    bit_v = tmr_done[n5];
                    st_nxt.tstart[n5] = st_r.stk[0];
                    st_nxt.seen_t[n5] = 1'b1;
                    bad = (arg[6:5] != 2'h0) || st_r.seen_t[n5];
                end
                OP_ASSIGN: begin
                    pop_n = 6'h01;
                    eq_end = 1'b1;
                    bad = (arg >= VO_LIM) || st_r.seen_v[arg];
                    if (arg < VO_LIM) begin
                        st_nxt.vo[arg] = st_r.stk[0];
                        st_nxt.seen_v[arg] = 1'b1;
                    end
                end
                OP_POS, OP_NEG, OP_DUAL: begin
                    pop_n = 6'h01;
                    push = 1'b1;
                    unique case (ent.op)
                        OP_POS: bit_v = st_r.stk[0] & ~st_r.osp[idx];
                        OP_NEG: bit_v = ~st_r.stk[0] & st_r.osp[idx];
                        default: bit_v = st_r.stk[0] ^ st_r.osp[idx];
                    endcase
                    st_nxt.osp[idx] = st_r.stk[0];
                    bad = ent.arg[6];
                end
                default: bad = 1'b1;
            endcase
        end
        // Results are consumed once: popping removes them from the stack.
        popped = st_r.stk >> pop_n;
        dep_n = DEP_W'(st_r.dep - pop_n + {5'h00, push});
        if (st_r.dep < pop_n || dep_n > DEP_MAX) begin
            bad = 1'b1;
        end
        unique case (st_r.ph)
            ST_CLEAR: begin
                st_nxt.addr = ADDR_W'(st_r.addr + 1'b1);
                if (st_r.addr == LAST_ADDR) begin
                    st_nxt.ph = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (tick) begin
                    st_nxt.ph = ST_RUN;
                    st_nxt.addr = '0;
                    st_nxt.stk = '0;
                    st_nxt.dep = '0;
                    st_nxt.seen_t = '0;
                    st_nxt.seen_v = '0;
                end
            end
            ST_RUN: begin
                st_nxt.stk = push ? {popped[STK_N-2:0], bit_v} : popped;
                st_nxt.dep = eq_end ? '0 : dep_n;
                st_nxt.err = st_r.err | bad;
                if (fin || st_r.addr == LAST_ADDR) begin
                    st_nxt.ph = ST_IDLE;
                    st_nxt.done = 1'b1;
                    st_nxt.tick_t = 1'b1;
                end else begin
                    st_nxt.addr = ADDR_W'(st_r.addr + 1'b1);
                end
            end
        endcase
        // A changed list is recompiled: latch, one-shot, timer and error state from the old list is dropped; virtual outputs keep their values.
        if ((LIST_WE_I && st_r.ph != ST_CLEAR) || LIST_CLR_I) begin
            st_nxt.lat = '0;
            st_nxt.osp = '0;
            st_nxt.tstart = '0;
            st_nxt.err = 1'b0;
            st_nxt.recomp = 1'b1;
            st_nxt.done = 1'b0;
            st_nxt.tick_t = 1'b0;
            st_nxt.ph = LIST_CLR_I ? ST_CLEAR : ST_IDLE;
            st_nxt.addr = '0;
        end
        st_nxt.busy = (st_nxt.ph != ST_IDLE);
    end

    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (st_r.ph == ST_CLEAR) begin
            list_mem[st_r.addr] <= '{op: OP_END, arg: '0};
        end else if (LIST_WE_I) begin
            list_mem[LIST_ADDR_I] <= LIST_DATA_I;
        end
    end

    fle_timer_bank u_timers (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .tick_i(st_r.tick_t),
        .clr_i(st_r.recomp),
        .start_i(st_r.tstart),
        .dly_i(TMR_DLY_I),
        .done_o(tmr_done)
    );

    assign VOUT_O = st_r.vo;
    assign SYNTAX_ERR_O = st_r.err;
    assign BUSY_O = st_r.busy;
    assign PASS_DONE_O = st_r.done;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    property p_gate_depth;
        run && !wr && ent.op == OP_OR && n5 >= GATE_LO && n5 <= GATE_HI && arg[6:5] == 2'h0
            && st_r.dep >= {1'b0, n5}
        |=> st_r.dep == DEP_W'($past(st_r.dep) - {1'b0, $past(n5)} + 6'h01);
    endproperty
    a_gate_depth: assert property (p_gate_depth) else $error("gate depth wrong");

    property p_xor;
        run && !wr && ent.op == OP_XOR && st_r.dep >= 6'h02
        |=> st_r.stk[0] == ($past(st_r.stk[0]) ^ $past(st_r.stk[1]));
    endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");

    property p_latch_rdom;
        run && !wr && ent.op == OP_LATCH && !arg[6] && st_r.stk[0]
        |=> !st_r.stk[0] && !st_r.lat[$past(idx)];
    endproperty
    a_latch_rdom: assert property (p_latch_rdom) else $error("latch reset lost");

    property p_latch_set;
        run && !wr && ent.op == OP_LATCH && !arg[6] && st_r.stk[1] && !st_r.stk[0]
        |=> st_r.stk[0] && st_r.lat[$past(idx)];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch set lost");

    property p_latch_hold;
        !wr && !(run && ent.op == OP_LATCH) |=> $stable(st_r.lat);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

    property p_timer;
        run && !wr && ent.op == OP_TIMER && arg[6:5] == 2'h0
        |=> st_r.tstart[$past(n5)] == $past(st_r.stk[0]);
    endproperty
    a_timer: assert property (p_timer) else $error("timer start wrong");

    property p_assign;
        run && !wr && ent.op == OP_ASSIGN && arg < VO_LIM
        |=> st_r.vo[$past(arg)] == $past(st_r.stk[0]) && st_r.dep == '0;
    endproperty
    a_assign: assert property (p_assign) else $error("assignment wrong");

    // A list write in the cycle after the duplicate recompiles and may drop the flag.
    property p_dup;
        run && !wr && ent.op == OP_ASSIGN && arg < VO_LIM && st_r.seen_v[arg] ##1 !wr
        |-> st_r.err ##1 st_r.err;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate not flagged");

    property p_seq;
        run && !wr && ent.op != OP_END && st_r.addr != LAST_ADDR
        |=> run && st_r.addr == ADDR_W'($past(st_r.addr) + 1'b1);
    endproperty
    a_seq: assert property (p_seq) else $error("entry order broken");

    property p_end;
        run && !wr && ent.op == OP_END |=> st_r.ph == ST_IDLE && PASS_DONE_O ##1 !PASS_DONE_O;
    endproperty
    a_end: assert property (p_end) else $error("end marker ignored");

    property p_recomp;
        LIST_WE_I && st_r.ph != ST_CLEAR |=> st_r.lat == '0 && !SYNTAX_ERR_O && !PASS_DONE_O;
    endproperty
    a_recomp: assert property (p_recomp) else $error("recompile kept latches");

    property p_clear;
        LIST_CLR_I |=> BUSY_O [*8] ##[1:520] !BUSY_O;
    endproperty
    a_clear: assert property (p_clear) else $error("list clear wrong length");

    property p_pos;
        run && !wr && ent.op == OP_POS && !arg[6] && st_r.dep != '0
        |=> st_r.stk[0] == ($past(st_r.stk[0]) && !$past(st_r.osp[idx]));
    endproperty
    a_pos: assert property (p_pos) else $error("one-shot wrong");

    c_latch: cover property (run && ent.op == OP_LATCH && st_r.stk[1]);
    c_assign: cover property (run && ent.op == OP_ASSIGN);
    c_done: cover property (PASS_DONE_O);
    c_err: cover property ($rose(SYNTAX_ERR_O));
endmodule

/* fle_evaluator_tb_top.sv */
`timescale 1ns/1ps
module fle_evaluator_tb_top;
    import fle_pkg::*;
    localparam int PC = 700;
    localparam int CYC_MAX = 90000;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic list_we = 1'b0;
    logic list_clr = 1'b0;
    logic [63:0] opnd = 64'h0;
    logic [ADDR_W-1:0] list_addr = '0;
    fle_entry_t list_data = '0;
    logic [TMR_N-1:0][DLY_W-1:0] tmr_dly = '0;
    logic [VO_N-1:0] vout;
    logic syn_err;
    logic busy;
    logic pass_done;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    fle_entry_t ent[$];

    fle_evaluator #(.PASS_CYCLES(PC)) u_dut (
        .CORE_CLK_I(core_clk),
        .RESET_I(rst),
        .OPND_I(opnd),
        .LIST_WE_I(list_we),
        .LIST_ADDR_I(list_addr),
        .LIST_DATA_I(list_data),
        .LIST_CLR_I(list_clr),
        .TMR_DLY_I(tmr_dly),
        .VOUT_O(vout),
        .SYNTAX_ERR_O(syn_err),
        .BUSY_O(busy),
        .PASS_DONE_O(pass_done)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_MAX) begin
            failures++;
            $display("CHECK FAILED run_time expected below %0d seen %0d", CYC_MAX, cyc);
            complete_run();
        end
    end

    task automatic chk_vec(string name, logic [95:0] exp, logic [95:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(string name, logic exp, logic got);
        chk_vec(name, {95'h0, exp}, {95'h0, got});
    endtask

    task automatic put(fle_op_t op, int arg);
        ent.push_back(fle_entry_t'{op: op, arg: ARG_W'(arg)});
    endtask

    // Writes the queued entries back to back from address 0, closed by an end marker.
    task automatic load();
        ent.push_back(fle_entry_t'{op: OP_END, arg: 7'h00});
        foreach (ent[i]) begin
            @(posedge core_clk);
            list_we <= 1'b1;
            list_addr <= ADDR_W'(i);
            list_data <= ent[i];
        end
        @(posedge core_clk);
        list_we <= 1'b0;
        ent.delete();
    endtask

    task automatic wait_pass();
        int n;
        n = 0;
        @(negedge core_clk);
        while (pass_done !== 1'b1 && n < 3 * PC) begin
            @(negedge core_clk);
            n++;
        end
        chk_bit("pass_done", 1'b1, pass_done);
    endtask

    task automatic wait_passes(int n);
        repeat (n) wait_pass();
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge core_clk);
        while (busy !== 1'b0 && n < 600) begin
            @(negedge core_clk);
            n++;
        end
        chk_bit("busy_after_clear", 1'b0, busy);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_idle();
    endtask

    task automatic set_opnd(logic [63:0] v);
        @(posedge core_clk);
        opnd <= v;
        wait_passes(2);
    endtask

    task automatic build_main();
        fle_op_t g[4];
        g = '{OP_OR, OP_AND, OP_NOR, OP_NAND};
        for (int k = 0; k < 4; k++) begin
            put(OP_IN, 20);
            for (int j = 0; j < 16; j++) begin
                put(OP_IN, j);
            end
            put(g[k], 16);
            put(OP_ASSIGN, k);
            put(OP_IN, 16);
            put(OP_IN, 17);
            put(g[k], 2);
            put(OP_ASSIGN, 4 + k);
        end
        put(OP_IN, 16);
        put(OP_IN, 17);
        put(OP_XOR, 2);
        put(OP_ASSIGN, 8);
        put(OP_IN, 18);
        put(OP_NOT, 0);
        put(OP_ASSIGN, 9);
        put(OP_IN, 21);
        put(OP_IN, 22);
        put(OP_LATCH, 0);
        put(OP_ASSIGN, 10);
        put(OP_IN, 23);
        put(OP_TIMER, 0);
        put(OP_ASSIGN, 11);
        put(OP_IN, 24);
        put(OP_VO, 12);
        put(OP_OR, 2);
        put(OP_ASSIGN, 12);
        put(OP_IN, 25);
        put(OP_POS, 0);
        put(OP_ASSIGN, 30);
        put(OP_IN, 25);
        put(OP_NEG, 1);
        put(OP_ASSIGN, 31);
        put(OP_IN, 25);
        put(OP_DUAL, 2);
        put(OP_ASSIGN, 32);
        put(OP_ON, 0);
        put(OP_ASSIGN, 15);
        put(OP_END, 0);
        put(OP_ON, 0);
        put(OP_ASSIGN, 16);
        load();
    endtask

    // Bit 20 stays low so a sixteen-input AND or NAND gate that took one result too many would differ.
    task automatic test_gates();
        logic [63:0] pat[3];
        logic [9:0] e;
        pat = '{64'h0000_0000_0003_FFFF, 64'h0000_0000_0005_0001, 64'h0};
        foreach (pat[i]) begin
            set_opnd(pat[i]);
            e = {~pat[i][18], pat[i][16] ^ pat[i][17], ~(pat[i][16] & pat[i][17]),
                 ~(pat[i][16] | pat[i][17]), pat[i][16] & pat[i][17],
                 pat[i][16] | pat[i][17], ~&pat[i][15:0], ~|pat[i][15:0],
                 &pat[i][15:0], |pat[i][15:0]};
            chk_vec("vout_gates", {86'h0, e}, {86'h0, vout[9:0]});
        end
        chk_bit("end_marker_before", 1'b1, vout[15]);
        chk_bit("end_marker_after", 1'b0, vout[16]);
        chk_bit("syntax_err_clean", 1'b0, syn_err);
    endtask

    task automatic test_latch();
        set_opnd(64'h0000_0000_0020_0000);
        chk_bit("latch_set", 1'b1, vout[10]);
        set_opnd(64'h0);
        chk_bit("latch_hold", 1'b1, vout[10]);
        set_opnd(64'h0000_0000_0060_0000);
        chk_bit("latch_both", 1'b0, vout[10]);
        set_opnd(64'h0000_0000_0020_0000);
        set_opnd(64'h0);
        chk_bit("latch_hold_again", 1'b1, vout[10]);
        build_main();
        wait_passes(2);
        chk_bit("latch_after_rewrite", 1'b0, vout[10]);
        set_opnd(64'h0000_0000_0020_0000);
        set_opnd(64'h0);
        do_reset();
        chk_vec("vout_after_reset", 96'h0, vout);
        wait_pass();
        chk_vec("vout_empty_list", 96'h0, vout);
        build_main();
        wait_passes(2);
        chk_bit("latch_after_reset", 1'b0, vout[10]);
    endtask

    task automatic test_timer_seal();
        @(posedge core_clk);
        opnd <= 64'h0000_0000_0080_0000;
        wait_passes(2);
        chk_bit("timer_early", 1'b0, vout[11]);
        wait_passes(5);
        chk_bit("timer_picked_up", 1'b1, vout[11]);
        set_opnd(64'h0);
        chk_bit("timer_dropped", 1'b0, vout[11]);
        chk_bit("seal_idle", 1'b0, vout[12]);
        set_opnd(64'h0000_0000_0100_0000);
        chk_bit("seal_pressed", 1'b1, vout[12]);
        set_opnd(64'h0);
        chk_bit("seal_held", 1'b1, vout[12]);
    endtask

    task automatic count_shots(output int c0, output int c1, output int c2);
        c0 = 0;
        c1 = 0;
        c2 = 0;
        repeat (5) begin
            wait_pass();
            c0 += int'(vout[30] === 1'b1);
            c1 += int'(vout[31] === 1'b1);
            c2 += int'(vout[32] === 1'b1);
        end
    endtask

    task automatic test_shots();
        int c0;
        int c1;
        int c2;
        @(posedge core_clk);
        opnd <= 64'h0000_0000_0200_0000;
        count_shots(c0, c1, c2);
        chk_vec("shots_rise", {32'h0000_0001, 32'h0000_0000, 32'h0000_0001},
                {32'(c0), 32'(c1), 32'(c2)});
        @(posedge core_clk);
        opnd <= 64'h0;
        count_shots(c0, c1, c2);
        chk_vec("shots_fall", {32'h0000_0000, 32'h0000_0001, 32'h0000_0001},
                {32'(c0), 32'(c1), 32'(c2)});
    endtask

    task automatic test_errors();
        put(OP_ON, 0);
        put(OP_ASSIGN, 40);
        put(OP_ON, 0);
        put(OP_ASSIGN, 40);
        load();
        wait_passes(2);
        chk_bit("err_dup_assign", 1'b1, syn_err);
        @(posedge core_clk);
        list_clr <= 1'b1;
        @(posedge core_clk);
        list_clr <= 1'b0;
        wait_idle();
        wait_pass();
        chk_bit("err_after_clear", 1'b0, syn_err);
        for (int k = 0; k < 2; k++) begin
            put(OP_ON, 0);
            put(OP_TIMER, 1);
            put(OP_ASSIGN, 41 + k);
        end
        load();
        wait_passes(2);
        chk_bit("err_dup_timer", 1'b1, syn_err);
    endtask

    initial begin
        for (int t = 0; t < TMR_N; t++) begin
            tmr_dly[t] = 8'h01;
        end
        tmr_dly[0] = 8'h02;
        // Timer 1 has no delay, so the duplicate-timer list also picks it up at once.
        tmr_dly[1] = 8'h00;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        wait_idle();
        build_main();
        test_gates();
        test_latch();
        test_timer_seal();
        test_shots();
        test_errors();
        complete_run();
    end
endmodule
